// [logic/bridge_ctl_pkg.sv]
// Purpose: shared constants for the bridge control and interrupt dword
// Assumes: 32-bit classic wishbone, byte addresses, one aligned word each
// Notes:   offsets are byte addresses; field positions index the 0x3c dword
`default_nettype none
package bridge_ctl_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL_DWORD = 8'h3c;  // routing, pin id, control
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h40;  // sticky event bits
   localparam logic [7:0] OFS_IRQ_MASK   = 8'h44;  // per-event enables
   // field positions inside the 0x3c dword
   localparam int ROUTE_LSB      = 0;
   localparam int PIN_ID_LSB     = 8;
   localparam int BIT_POISON_EN  = 16;
   localparam int BIT_ERR_FWD_EN = 17;
   localparam int BIT_ISA_EN     = 18;
   localparam int BIT_VGA_EN     = 19;
   localparam int BIT_VGA_16BIT  = 20;
   localparam int BIT_SEC_RESET  = 22;
   // writable control bits; all others in 31:16 read zero
   localparam logic [31:0] CTRL_WR_MASK = 32'h005f_0000;
   // reset values
   localparam logic [7:0]  ROUTE_RESET  = 8'h00;
   localparam logic [7:0]  PIN_ID_RESET = 8'h00;
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
   // interrupt event bits
   localparam int EV_HOTPLUG = 0;
   localparam int EV_POISON  = 1;
   localparam int EV_ERR_MSG = 2;
   localparam int NUM_EV     = 3;
   // legacy vga memory window
   localparam logic [31:0] VGA_MEM_LO = 32'h000a_0000;
   localparam logic [31:0] VGA_MEM_HI = 32'h000b_ffff;
   // legacy vga i/o ranges on address bits 9:0
   localparam logic [9:0]  VGA_IO_A_LO = 10'h3b0;
   localparam logic [9:0]  VGA_IO_A_HI = 10'h3bb;
   localparam logic [9:0]  VGA_IO_B_LO = 10'h3c0;
   localparam logic [9:0]  VGA_IO_B_HI = 10'h3df;
   // error message kinds
   typedef enum logic [1:0] {
      ERR_COR      = 2'b00,
      ERR_NONFATAL = 2'b01,
      ERR_FATAL    = 2'b10
   } err_kind_t;
endpackage
`default_nettype wire

// [logic/fwd_decode_if.sv]
// Purpose: carries one address decode between the register block and decoder
// Assumes: single clock, combinational answer
// Notes:   the register side drives the request and the control bits
`default_nettype none
interface fwd_decode_if;
   logic [31:0] addr;       // transaction address
   logic        is_io;      // i/o space when high, memory otherwise
   logic        in_window;  // inside the base/limit window
   logic        isa_en;     // control bit copies
   logic        vga_en;
   logic        vga_16bit;
   logic        fwd_down;   // decoder answers
   logic        fwd_up;
   logic        vga_hit;
   modport regs    (output addr, is_io, in_window, isa_en, vga_en, vga_16bit,
                    input fwd_down, fwd_up, vga_hit);
   modport decoder (input addr, is_io, in_window, isa_en, vga_en, vga_16bit,
                    output fwd_down, fwd_up, vga_hit);
endinterface
`default_nettype wire

// [logic/fwd_decode.sv]
// Purpose: routes one address by the isa and vga control bits
// Assumes: window hit already worked out by the caller
// Notes:   purely combinational; the caller registers the answer
`default_nettype none
module fwd_decode
   import bridge_ctl_pkg::*;
(
   // decode request and answer
   fwd_decode_if.decoder dec
);
   logic       low_64k;   // i/o address below 64KB
   logic       alias_ok;  // upper i/o bits allow a vga match
   logic       io_vga;    // vga i/o range hit
   logic       mem_vga;   // vga memory range hit
   logic       isa_top;   // top 768 bytes of a 1KB block
   logic [9:0] lo10;      // low ten address bits

   assign lo10    = dec.addr[9:0];
   assign low_64k = (dec.addr[31:16] == 16'h0000);
   // ten-bit decode lets aliases in bits 15:10 match
   assign alias_ok = dec.vga_16bit ? (dec.addr[15:10] == 6'h00) : 1'b1;
   assign io_vga = dec.is_io && low_64k && alias_ok &&
                   (((lo10 >= VGA_IO_A_LO) && (lo10 <= VGA_IO_A_HI)) ||
                    ((lo10 >= VGA_IO_B_LO) && (lo10 <= VGA_IO_B_HI)));
   assign mem_vga = !dec.is_io && (dec.addr >= VGA_MEM_LO) &&
                    (dec.addr <= VGA_MEM_HI);
   // offsets 100h..3ffh of each 1KB block
   assign isa_top = dec.is_io && low_64k && (dec.addr[9:8] != 2'b00);

   // vga overrides the window; clear vga bit ignores the range
   assign dec.vga_hit  = dec.vga_en && (io_vga || mem_vga);
   assign dec.fwd_up   = dec.is_io && dec.in_window && dec.isa_en && isa_top
                         && !dec.vga_hit;
   assign dec.fwd_down = dec.vga_hit ||
                         (dec.in_window && !dec.fwd_up);
endmodule // fwd_decode
`default_nettype wire

// [logic/bridge_control_interrupt_regs.sv]
// Purpose: bridge control dword, pin identifier and event interrupts
// Assumes: classic wishbone slave, one clock, inputs synchronous to clk
// Notes:   ack comes one cycle after a request is seen, then drops
`default_nettype none
module bridge_control_interrupt_regs
   import bridge_ctl_pkg::*;
#(
   parameter bit IS_UPSTREAM = 1'b0, // upstream port drives every reset
   parameter int NUM_RST     = 1     // reset outputs driven by this port
)(
   // clock and reset
   input  wire logic                clk,
   input  wire logic                resetn,
   // wishbone slave
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [7:0]          wb_adr_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic [31:0]         wb_dat_i,
   output logic      [31:0]         wb_dat_o,
   output logic                     wb_ack_o,
   // pin identifier reload from management bus or eeprom
   input  wire logic                pin_id_load,
   input  wire logic [7:0]          pin_id_value,
   // events from the port
   input  wire logic                hotplug_event,
   input  wire logic                poison_seen,
   input  wire logic                err_msg_valid,
   input  wire logic [1:0]          err_msg_kind,
   // address decode request
   input  wire logic                dec_valid,
   input  wire logic [31:0]         dec_addr,
   input  wire logic                dec_is_io,
   input  wire logic                dec_in_window,
   // results
   output logic                     poison_report,
   output logic                     err_fwd_valid,
   output logic      [1:0]          err_fwd_kind,
   output logic                     fwd_valid,
   output logic                     fwd_down,
   output logic                     fwd_up,
   output logic                     fwd_vga,
   output logic      [NUM_RST-1:0]  port_rst_n,
   output logic                     irq
);
   // refuse port shapes that the reset fan-out cannot serve
   if (NUM_RST < 1 || (!IS_UPSTREAM && NUM_RST != 1))
   begin : g_bad_num_rst
      $error("NUM_RST must be 1 on a downstream port and at least 1");
   end

   logic              req;          // new bus request this cycle
   logic              wr;           // request is a write
   logic [31:0]       bmask;        // byte enables spread to bits
   logic [7:0]        route_q;      // interrupt routing byte, software only
   logic [7:0]        pin_id_q;     // interrupt pin identifier
   logic [31:0]       ctrl_q;       // writable bridge control bits
   logic [NUM_EV-1:0] status_q;     // sticky events
   logic [NUM_EV-1:0] mask_q;       // event enables
   logic [NUM_EV-1:0] ev;           // events this cycle
   logic [NUM_EV-1:0] clr;          // write-one-to-clear strobes
   logic [31:0]       dword;        // assembled 0x3c value
   logic [31:0]       rdata;        // read mux

   fwd_decode_if dif ();

   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr  = req && wb_we_i;

   // byte enables widened to a bit mask
   genvar gb;
   generate
      for (gb = 0; gb < 4; gb++)
      begin : g_bmask
         assign bmask[gb*8 +: 8] = {8{wb_sel_i[gb]}};
      end
   endgenerate

   // hardwired and reserved bits come out as zero through the mask
   assign dword = (ctrl_q & CTRL_WR_MASK) |
                  {16'h0000, pin_id_q, route_q};

   // bus ack: one cycle after the request, dropped the cycle after
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= req;
   end

   // read mux; unmapped offsets answer zero with a normal ack
   always_comb
   begin
      unique case (wb_adr_i & 8'hfc)
         OFS_CTRL_DWORD: rdata = dword;
         OFS_IRQ_STATUS: rdata = {{(32-NUM_EV){1'b0}}, status_q};
         OFS_IRQ_MASK:   rdata = {{(32-NUM_EV){1'b0}}, mask_q};
         default:        rdata = 32'h0000_0000;
      endcase
   end

   // read data is latched with the ack so it stands from a flop
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         wb_dat_o <= 32'h0000_0000;
      else if (req && !wb_we_i)
         wb_dat_o <= rdata;
   end

   // routing byte: stored only, nothing in the block reads it
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         route_q <= ROUTE_RESET;
      else if (wr && (wb_adr_i & 8'hfc) == OFS_CTRL_DWORD && wb_sel_i[0])
         route_q <= wb_dat_i[ROUTE_LSB +: 8];
   end

   // pin identifier: read-only to the bus, reloaded by management on a downstream port only
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         pin_id_q <= PIN_ID_RESET;
      else if (pin_id_load && !IS_UPSTREAM)
         pin_id_q <= pin_id_value;
   end

   // writable control bits; only the mask bits ever take a one
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         ctrl_q <= CTRL_RESET;
      else if (wr && (wb_adr_i & 8'hfc) == OFS_CTRL_DWORD)
         ctrl_q <= (ctrl_q & ~(bmask & CTRL_WR_MASK)) |
                   (wb_dat_i & bmask & CTRL_WR_MASK);
   end

   // events; a poisoned packet counts only while detection is on
   assign ev[EV_HOTPLUG] = hotplug_event;
   assign ev[EV_POISON]  = poison_seen && ctrl_q[BIT_POISON_EN];
   assign ev[EV_ERR_MSG] = err_msg_valid && ctrl_q[BIT_ERR_FWD_EN];
   assign clr = (wr && (wb_adr_i & 8'hfc) == OFS_IRQ_STATUS && wb_sel_i[0])
                ? wb_dat_i[NUM_EV-1:0] : '0;

   // sticky status: an event in the clearing cycle survives
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         status_q <= '0;
      else
         status_q <= (status_q & ~clr) | ev;
   end

   // mask register
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         mask_q <= '0;
      else if (wr && (wb_adr_i & 8'hfc) == OFS_IRQ_MASK && wb_sel_i[0])
         mask_q <= wb_dat_i[NUM_EV-1:0];
   end

   // level interrupt, doubling as the INTA virtual wire level
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         irq <= 1'b0;
      else
         irq <= |(status_q & mask_q);
   end

   // poisoned packet report pulse
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         poison_report <= 1'b0;
      else
         poison_report <= poison_seen && ctrl_q[BIT_POISON_EN];
   end

   // error message forwarding, blocked while the enable is clear
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         err_fwd_valid <= 1'b0;
         err_fwd_kind  <= ERR_COR;
      end
      else
      begin
         err_fwd_valid <= err_msg_valid && ctrl_q[BIT_ERR_FWD_EN];
         if (err_msg_valid)
            err_fwd_kind <= err_msg_kind;
      end
   end

   // hot reset: every output follows bit 22; a downstream port has one
   genvar gr;
   generate
      for (gr = 0; gr < NUM_RST; gr++)
      begin : g_rst
         always_ff @(posedge clk or negedge resetn)
         begin
            if (!resetn)
               port_rst_n[gr] <= 1'b1;
            else
               port_rst_n[gr] <= !ctrl_q[BIT_SEC_RESET];
         end
      end
   endgenerate

   // address decode through the shared decoder
   assign dif.addr      = dec_addr;
   assign dif.is_io     = dec_is_io;
   assign dif.in_window = dec_in_window;
   assign dif.isa_en    = ctrl_q[BIT_ISA_EN];
   assign dif.vga_en    = ctrl_q[BIT_VGA_EN];
   assign dif.vga_16bit = ctrl_q[BIT_VGA_16BIT];

   fwd_decode u_dec (
      .dec (dif.decoder)
   );

   // decode answer registered one cycle after the request
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         fwd_valid <= 1'b0;
         fwd_down  <= 1'b0;
         fwd_up    <= 1'b0;
         fwd_vga   <= 1'b0;
      end
      else
      begin
         fwd_valid <= dec_valid;
         fwd_down  <= dec_valid && dif.fwd_down;
         fwd_up    <= dec_valid && dif.fwd_up;
         fwd_vga   <= dec_valid && dif.vga_hit;
      end
   end

   // checks
   sequence s_rd_ctrl;
      req && !wb_we_i && (wb_adr_i & 8'hfc) == OFS_CTRL_DWORD;
   endsequence

   property p_hardwired;
      @(posedge clk) disable iff (!resetn)
      s_rd_ctrl |=> (wb_ack_o && wb_dat_o[27:23] == 5'h00 &&
                     !wb_dat_o[21]);
   endproperty
   a_hardwired: assert property (p_hardwired)
      else $error("hardwired control bits read nonzero");

   property p_reserved;
      @(posedge clk) disable iff (!resetn)
      s_rd_ctrl |=> wb_dat_o[31:28] == 4'h0;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved control bits read nonzero");

   property p_rst_follow;
      @(posedge clk) disable iff (!resetn)
      ctrl_q[BIT_SEC_RESET] |=> (port_rst_n == '0);
   endproperty
   a_rst_follow: assert property (p_rst_follow)
      else $error("hot reset bit set but reset output not asserted");

   property p_rst_quiet;
      @(posedge clk) disable iff (!resetn)
      !ctrl_q[BIT_SEC_RESET] |=> (port_rst_n == '1);
   endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("reset output asserted with hot reset bit clear");

   property p_poison_gate;
      @(posedge clk) disable iff (!resetn)
      poison_seen |=> (poison_report == $past(ctrl_q[BIT_POISON_EN]));
   endproperty
   a_poison_gate: assert property (p_poison_gate)
      else $error("poisoned packet report does not follow its enable");

   property p_err_block;
      @(posedge clk) disable iff (!resetn)
      (err_msg_valid && !ctrl_q[BIT_ERR_FWD_EN]) |=> !err_fwd_valid;
   endproperty
   a_err_block: assert property (p_err_block)
      else $error("error message forwarded while forwarding disabled");

   property p_err_fwd;
      @(posedge clk) disable iff (!resetn)
      (err_msg_valid && ctrl_q[BIT_ERR_FWD_EN]) |=>
         (err_fwd_valid && err_fwd_kind == $past(err_msg_kind));
   endproperty
   a_err_fwd: assert property (p_err_fwd)
      else $error("enabled error message not forwarded");

   property p_vga_off;
      @(posedge clk) disable iff (!resetn)
      (dec_valid && !ctrl_q[BIT_VGA_EN]) |=> !fwd_vga;
   endproperty
   a_vga_off: assert property (p_vga_off)
      else $error("vga range claimed while vga forwarding off");

   property p_vga_mem;
      @(posedge clk) disable iff (!resetn)
      (dec_valid && ctrl_q[BIT_VGA_EN] && !dec_is_io &&
       dec_addr >= VGA_MEM_LO && dec_addr <= VGA_MEM_HI)
         |=> (fwd_vga && fwd_down);
   endproperty
   a_vga_mem: assert property (p_vga_mem)
      else $error("vga memory address not forwarded");

   property p_vga_alias;
      @(posedge clk) disable iff (!resetn)
      (dec_valid && ctrl_q[BIT_VGA_EN] && dec_is_io &&
       dec_addr[31:16] == 16'h0000 && dec_addr[15:10] != 6'h00 &&
       dec_addr[9:0] == VGA_IO_B_LO)
         |=> (fwd_vga == !$past(ctrl_q[BIT_VGA_16BIT]));
   endproperty
   a_vga_alias: assert property (p_vga_alias)
      else $error("vga alias decode does not follow the width bit");

   property p_isa_up;
      @(posedge clk) disable iff (!resetn)
      (dec_valid && ctrl_q[BIT_ISA_EN] && !ctrl_q[BIT_VGA_EN] && dec_is_io
       && dec_in_window && dec_addr[31:16] == 16'h0000 &&
       dec_addr[9:8] != 2'b00) |=> (fwd_up && !fwd_down);
   endproperty
   a_isa_up: assert property (p_isa_up)
      else $error("isa top range not sent upstream");

   property p_irq;
      @(posedge clk) disable iff (!resetn)
      (|(status_q & mask_q)) |=> irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("unmasked event without interrupt");

   property p_route_inert;
      @(posedge clk) disable iff (!resetn)
      !(wr && (wb_adr_i & 8'hfc) == OFS_CTRL_DWORD && wb_sel_i[0])
         |=> $stable(route_q);
   endproperty
   a_route_inert: assert property (p_route_inert)
      else $error("routing byte changed without a write");
endmodule // bridge_control_interrupt_regs
`default_nettype wire

// [bench/cfg_host_model.sv]
// Purpose: host side that issues config accesses over classic wishbone
// Assumes: the slave acks every request within a short bounded wait
// Notes:   released address and data lines carry inverted last values; we and sel keep theirs
`default_nettype none
module cfg_host_model (
   // clock
   input  wire logic        clk,
   // wishbone master side
   output var  logic        cyc,
   output var  logic        stb,
   output var  logic        we,
   output var  logic [7:0]  adr,
   output var  logic [3:0]  sel,
   output var  logic [31:0] dat,
   input  wire logic        ack,
   input  wire logic [31:0] din
);
   timeunit 1ns;
   timeprecision 1ns;
   bit hung = 1'b0;  // raised when an ack never came
   // bus idle at time zero
   initial
   begin
      cyc = 1'b0;
      stb = 1'b0;
      we  = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      dat = 32'h0;
   end
   // one classic cycle; holds everything until ack is sampled high
   task automatic xfer(input bit w, input logic [7:0] a,
                       input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      sel <= 4'hf;
      dat <= d;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      if (n >= 20)
         hung = 1'b1;
      // release; inverted values so nothing stale looks valid
      cyc <= 1'b0;
      stb <= 1'b0;
      adr <= ~a;
      dat <= ~d;
      // random idle gap: prompt or slow host
      repeat ($urandom_range(0, 2)) @(posedge clk);
   endtask
endmodule // cfg_host_model
`default_nettype wire

// [bench/test_bridge_control_interrupt_regs.sv]
// Purpose: self-checking bench for the bridge control dword block
// Assumes: downstream port, one reset output, 20 MHz clock
// Notes:   drivers queue expectations, one monitor pops and compares
`default_nettype none
module test_bridge_control_interrupt_regs
   import bridge_ctl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, resetn = 1'b0;  // clock and reset
   logic cyc, stb, we, ack, ld = 1'b0, hp = 1'b0, ps = 1'b0, ev = 1'b0;
   logic dv = 1'b0, io = 1'b0, win = 1'b0, prep, efv, fv, fd, fu, fg;
   logic irq;
   logic [0:0]  prst;                // port reset output, low active
   logic [1:0]  ek = 2'b00, efk;     // error kinds in and out
   logic [3:0]  sel;
   logic [7:0]  adr, pv = 8'h00;
   logic [31:0] wd, rdat, da = 32'h0, ctl;
   logic [31:0] q_rd[$];             // expected read data
   logic [2:0]  q_fwd[$];            // expected {down, up, vga}
   logic [1:0]  q_err[$];            // expected forwarded kinds
   logic        q_poi[$];            // expected poison reports
   int n_errors = 0, tests_run = 0;
   // 34-bit entries: {is_io, in_window, address}
   localparam logic [33:0] TBL [14] = '{
      {2'b11, 32'h100}, {2'b11, 32'h50}, {2'b11, 32'h10100},
      {2'b11, 32'h3c0}, {2'b10, 32'h3b0}, {2'b10, 32'h3bb},
      {2'b10, 32'h3bc}, {2'b10, 32'h3df}, {2'b10, 32'h3e0},
      {2'b10, 32'h13c0}, {2'b10, 32'h103c0}, {2'b00, 32'ha0000},
      {2'b00, 32'hbffff}, {2'b00, 32'hc0000}};
   always #25 clk = ~clk;
   cfg_host_model i_host (.clk(clk), .cyc(cyc), .stb(stb), .we(we),
      .adr(adr), .sel(sel), .dat(wd), .ack(ack), .din(rdat));
   bridge_control_interrupt_regs i_dut (.clk(clk), .resetn(resetn),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
      .pin_id_load(ld), .pin_id_value(pv), .hotplug_event(hp),
      .poison_seen(ps), .err_msg_valid(ev), .err_msg_kind(ek),
      .dec_valid(dv), .dec_addr(da), .dec_is_io(io),
      .dec_in_window(win), .poison_report(prep), .err_fwd_valid(efv),
      .err_fwd_kind(efk), .fwd_valid(fv), .fwd_down(fd), .fwd_up(fu),
      .fwd_vga(fg), .port_rst_n(prst), .irq(irq));
   // generic comparison, counts and reports
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
      cmp(g, e);
   endtask
   task automatic cmp_fwd(input logic [2:0] g, input logic [2:0] e);
      cmp({29'h0, g}, {29'h0, e});
   endtask
   task automatic cmp_err(input logic [1:0] g, input logic [1:0] e);
      cmp({30'h0, g}, {30'h0, e});
   endtask
   task automatic cmp_lvl(input logic g, input logic e);
      cmp({31'h0, g}, {31'h0, e});
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // monitor: a result with no note pops x, which never matches
   always @(posedge clk)
   begin
      if (ack === 1'b1 && we === 1'b0)
         cmp_rd(rdat, q_rd.size() ? q_rd.pop_front() : 'x);
      if (fv === 1'b1)
         cmp_fwd({fd, fu, fg},
                 q_fwd.size() ? q_fwd.pop_front() : 'x);
      if (efv === 1'b1)
         cmp_err(efk, q_err.size() ? q_err.pop_front() : 'x);
      if (prep === 1'b1)
         cmp_lvl(1'b1, q_poi.size() ? q_poi.pop_front() : 'x);
      if (i_host.hung)
      begin
         n_errors++;
         end_of_test();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_host.xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      q_rd.push_back(e);
      i_host.xfer(1'b0, a, 32'h0);
   endtask
   task automatic wctl(input logic [31:0] d);
      ctl = d;
      wr(OFS_CTRL_DWORD, d);
   endtask
   // one-cycle event pulse: 0 hotplug, 1 poison, 2 error message
   task automatic pulse(input int k, input logic [1:0] kind);
      @(posedge clk);
      hp <= (k == 0);
      ps <= (k == 1);
      ev <= (k == 2);
      ek <= kind;
      @(posedge clk);
      hp <= 1'b0;
      ps <= 1'b0;
      ev <= 1'b0;
   endtask
   // expected routing, worked out from the control bits and the request alone
   function automatic logic [2:0] exp_fwd(logic [31:0] c, logic [31:0] a,
                                         logic i, logic w);
      logic lo, vio, vm, hit, up;
      lo  = a[31:16] == 16'h0;
      vio = i && lo && (!c[20] || a[15:10] == 6'h0) &&
            ((a[9:0] >= VGA_IO_A_LO && a[9:0] <= VGA_IO_A_HI) ||
             (a[9:0] >= VGA_IO_B_LO && a[9:0] <= VGA_IO_B_HI));
      vm  = !i && a >= VGA_MEM_LO && a <= VGA_MEM_HI;
      hit = c[19] && (vio || vm);
      up  = !hit && i && w && c[18] && lo && a[9:8] != 2'b00;
      return {hit || (w && !up), up, hit};
   endfunction
   task automatic dec(input logic [31:0] a, input logic i, input logic w);
      q_fwd.push_back(exp_fwd(ctl, a, i, w));
      @(posedge clk);
      dv  <= 1'b1;
      da  <= a;
      io  <= i;
      win <= w;
      @(posedge clk);
      dv  <= 1'b0;
      da  <= ~a;
   endtask
   // bounded drain of pending notes, then one report line
   task automatic done(input string s);
      int n;
      n = 0;
      while ((q_rd.size() + q_fwd.size() + q_err.size() + q_poi.size())
             != 0 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      cmp_lvl(n < 20, 1'b1);
      if (n >= 20)
         end_of_test();
      $display("test %s finished", s);
   endtask
   task automatic do_reset;
      resetn <= 1'b0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      ctl = 32'h0;
   endtask
   // main sequence
   initial
   begin
      logic [31:0] v;
      void'($urandom(32'hb20f));
      do_reset();
      rd(OFS_CTRL_DWORD, 32'h0);
      cmp_lvl(prst[0], 1'b1);
      done("reset values");
      wctl(32'hffff_ffff);
      rd(OFS_CTRL_DWORD, CTRL_WR_MASK | 32'hff);
      repeat (2) @(posedge clk);
      cmp_lvl(prst[0], 1'b0);
      wctl(32'h0);
      repeat (2) @(posedge clk);
      cmp_lvl(prst[0], 1'b1);
      wr(8'h80, $urandom());
      rd(8'h80, 32'h0);
      done("control bits");
      repeat (4)
      begin
         v = $urandom();
         wctl(v & 32'hffa0_00ff);
         rd(OFS_CTRL_DWORD, v & 32'h0000_00ff);
      end
      v = $urandom();
      @(posedge clk);
      ld <= 1'b1;
      pv <= v[7:0];
      @(posedge clk);
      ld <= 1'b0;
      rd(OFS_CTRL_DWORD, {16'h0, v[7:0], ctl[7:0]});
      done("routing and pin id");
      wctl(32'h0);
      pulse(1, 2'b00);
      wctl(32'h1 << BIT_POISON_EN);
      q_poi.push_back(1'b1);
      pulse(1, 2'b00);
      wctl(32'h0);
      for (int k = 0; k < 3; k++)
         pulse(2, k[1:0]);
      wctl(32'h1 << BIT_ERR_FWD_EN);
      for (int k = 0; k < 3; k++)
      begin
         q_err.push_back(k[1:0]);
         pulse(2, k[1:0]);
      end
      done("poison and errors");
      for (int c = 0; c < 8; c++)
      begin
         wctl({11'h0, c[2:0], 18'h0});
         foreach (TBL[j])
            dec(TBL[j][31:0], TBL[j][33], TBL[j][32]);
         for (int j = 0; j < 4; j++)
            dec({16'h0, 16'($urandom())}, 1'b1, 1'($urandom()));
      end
      done("address decode");
      wr(OFS_IRQ_STATUS, 32'h7);
      wr(OFS_IRQ_MASK, 32'h0);
      pulse(0, 2'b00);
      rd(OFS_IRQ_STATUS, 32'h1);
      cmp_lvl(irq, 1'b0);
      wr(OFS_IRQ_MASK, 32'h1);
      repeat (3) @(posedge clk);
      cmp_lvl(irq, 1'b1);
      wr(OFS_IRQ_STATUS, 32'h1);
      repeat (3) @(posedge clk);
      cmp_lvl(irq, 1'b0);
      rd(OFS_IRQ_STATUS, 32'h0);
      done("interrupts");
      wctl(32'h0040_00a5);
      do_reset();
      rd(OFS_CTRL_DWORD, 32'h0);
      cmp_lvl(prst[0], 1'b1);
      done("second reset");
      end_of_test();
   end
endmodule // test_bridge_control_interrupt_regs
`default_nettype wire
